// >>> inc/cx_map.vh
// Constants for the execute-subset datapath: encodings, flags and APB map
`ifndef CX_MAP_VH
`define CX_MAP_VH

// 14-bit instruction opcodes (upper bits)
`define CX_OP_NOP          14'h0000
`define CX_OP6_ADD_FILE    6'h07
`define CX_OP6_AND_FILE    6'h05
`define CX_OP6_COPY_FILE   6'h08
`define CX_OP7_COPY_ACC    7'h01
`define CX_OP4_BIT_CLEAR   4'h4
`define CX_OP4_BIT_SET     4'h5
`define CX_OP4_TEST_SKIP   4'h7
`define CX_OP6_ADD_IMM     6'h3e
`define CX_OP6_AND_IMM     6'h39
`define CX_OP4_LOAD_IMM    4'hc

// Status flag positions
`define CX_FLAG_CARRY      0
`define CX_FLAG_HALF       1
`define CX_FLAG_ZERO       2

// Oscillator periods per instruction cycle
`define CX_OSC_PER_CYCLE   4

// APB register byte offsets
`define CX_REG_INSTR       12'h000
`define CX_REG_ACC         12'h004
`define CX_REG_STATUS      12'h008
`define CX_REG_FILE_BASE   12'h200
`define CX_REG_EXEC_COUNT  12'h00c

// Reset values
`define CX_RST_ACC         8'h00
`define CX_RST_STATUS      3'h0

`endif

// >>> core/cx_phase.v
// Instruction-cycle phase generator: four oscillator periods per cycle
`timescale 1ns/1ps
`include "cx_map.vh"

module cx_phase
#(
  parameter PHASES = `CX_OSC_PER_CYCLE
)
(
  input  wire       sys_clk,
  input  wire       arst_n,
  input  wire       start,
  output reg  [1:0] phase_r,
  output reg        busy_r,
  output reg        exec_r
);

  reg [1:0] phase_nxt;

  // Phase counter runs only while an instruction is in flight
  always @*
  begin
    phase_nxt = phase_r;
    if (busy_r)
      phase_nxt = phase_r + 2'h1;
  end

  // Execute strobe fires on the last of the four periods
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_r <= 2'h0;
      busy_r  <= 1'b0;
      exec_r  <= 1'b0;
    end
    else
    begin
      phase_r <= busy_r ? phase_nxt : 2'h0;
      exec_r  <= busy_r && (phase_r == PHASES[1:0] - 2'h2);
      if (start && !busy_r)
        busy_r <= 1'b1;
      else if (busy_r && phase_r == PHASES[1:0] - 2'h1)
        busy_r <= 1'b0;
    end
  end

endmodule // cx_phase

// >>> core/cx_execute.v
// Execute datapath for a subset of an 8-bit core, with an APB slave
`timescale 1ns/1ps
`include "cx_map.vh"

// Notes on behaviour
// - Add immediate into accumulator; carry, half carry and zero updated.
// - Add accumulator and file register into destination; all flags.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Bit clear zeroes one file bit, flags untouched.
// - Bit set forces one file bit to one, flags untouched.
// - AND immediate with accumulator into accumulator, only Z updated.
// - AND accumulator with file, result to destination, only Z updated.
// - Bit test skips next instruction as a no-op when bit is one.
// - Copy file to destination updates Z; one word, one cycle.
// - Copy accumulator to file register, flags untouched, one cycle.
// - Load immediate into accumulator, flags untouched, one cycle.
// - One instruction cycle spans four clock periods.
module cx_execute
#(
  parameter FILE_DEPTH = 128
)
(
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [7:0]  acc_out,
  output reg  [2:0]  flags_out,
  output reg         skip_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Architectural state: file, accumulator, flags, pending skip, word
  reg  [7:0]  file_r [0:FILE_DEPTH-1];
  reg  [7:0]  acc_r;
  reg  [2:0]  status_r;
  reg         skip_r;
  reg  [13:0] instr_r;
  reg  [15:0] exec_count_r;
  // Next values and datapath temporaries, all set by the decode process
  reg  [7:0]  acc_nxt;
  reg  [2:0]  status_nxt;
  reg         skip_nxt;
  reg  [7:0]  fres_nxt;
  reg         fwr_nxt;
  reg  [8:0]  sum;
  reg  [4:0]  low_sum;
  reg  [7:0]  bit_mask;

  // Sequencer handshakes, bus decode and the operand fields of the word
  wire        start;
  wire [1:0]  phase;
  wire        busy;
  wire        exec;
  wire [2:0]  reg_sel;
  wire        answer_now;
  wire [6:0]  faddr = instr_r[6:0];
  wire        dest  = instr_r[7];
  wire [2:0]  bsel  = instr_r[9:7];
  wire [7:0]  imm   = instr_r[7:0];
  wire [7:0]  fval  = file_r[faddr];

  // Bus register select codes; binary so the read mux is a plain case
  localparam [2:0] SEL_INSTR  = 3'h0;
  localparam [2:0] SEL_ACC    = 3'h1;
  localparam [2:0] SEL_STATUS = 3'h2;
  localparam [2:0] SEL_COUNT  = 3'h3;
  localparam [2:0] SEL_FILE   = 3'h4;
  localparam [2:0] SEL_NONE   = 3'h7;

  // Mask with a single bit set at the chosen position
  function [7:0] cx_bit_mask;
    input [2:0] pos;
    begin
      cx_bit_mask = 8'h01 << pos;
    end
  endfunction

  // Zero test shared by all flag updates
  function cx_is_zero;
    input [7:0] v;
    begin
      cx_is_zero = (v == 8'h00);
    end
  endfunction

  // Bus address decode, shared by the write path and the read mux
  function [2:0] cx_reg_sel;
    input [11:0] a;
    begin
      if (a[11:9] == 3'h1)
        cx_reg_sel = SEL_FILE;
      else if (a == `CX_REG_INSTR)
        cx_reg_sel = SEL_INSTR;
      else if (a == `CX_REG_ACC)
        cx_reg_sel = SEL_ACC;
      else if (a == `CX_REG_STATUS)
        cx_reg_sel = SEL_STATUS;
      else if (a == `CX_REG_EXEC_COUNT)
        cx_reg_sel = SEL_COUNT;
      else
        cx_reg_sel = SEL_NONE;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Instruction cycle sequencing
  // ----------------------------------------------------------------------
  // One decode of the bus address feeds the write path and the read mux
  assign reg_sel = cx_reg_sel(paddr);

  // The slave answers only while the core is idle; an instruction in
  // flight holds every access off, so software only sees settled state
  assign answer_now = psel && penable && !pready && !busy;

  // A write to the instruction register starts one four-period cycle;
  // it is taken at the edge where the master sees pready high
  assign start = psel && penable && pwrite && pready
                 && (reg_sel == SEL_INSTR);

  // Four clock periods make one instruction cycle; exec marks the last
  cx_phase #(
    .PHASES (`CX_OSC_PER_CYCLE)
  ) u_phase (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .start   (start),
    .phase_r (phase),
    .busy_r  (busy),
    .exec_r  (exec)
  );

  // ----------------------------------------------------------------------
  // Execute decode
  // ----------------------------------------------------------------------
  // All results settle here; state is committed only on the exec strobe
  always @*
  begin
    acc_nxt    = acc_r;
    status_nxt = status_r;
    skip_nxt   = 1'b0;
    fres_nxt   = fval;
    fwr_nxt    = 1'b0;
    sum        = 9'h000;
    low_sum    = 5'h00;
    bit_mask   = cx_bit_mask(bsel);
    if (skip_r)
    begin
      // Discarded instruction runs as a no-op in its place
      skip_nxt = 1'b0;
    end
    else if (instr_r[13:8] == `CX_OP6_ADD_FILE)
    begin
      // A nine-bit sum yields the carry out of bit 7 and a five-bit sum
      // the carry out of bit 3, so both carries come from plain adders
      sum     = {1'b0, acc_r} + {1'b0, fval};
      low_sum = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]};
      status_nxt[`CX_FLAG_CARRY] = sum[8];
      status_nxt[`CX_FLAG_HALF]  = low_sum[4];
      status_nxt[`CX_FLAG_ZERO]  = cx_is_zero(sum[7:0]);
      if (dest)
      begin
        fres_nxt = sum[7:0];
        fwr_nxt  = 1'b1;
      end
      else
        acc_nxt = sum[7:0];
    end
    else if (instr_r[13:8] == `CX_OP6_ADD_IMM)
    begin
      sum     = {1'b0, acc_r} + {1'b0, imm};
      low_sum = {1'b0, acc_r[3:0]} + {1'b0, imm[3:0]};
      status_nxt[`CX_FLAG_CARRY] = sum[8];
      status_nxt[`CX_FLAG_HALF]  = low_sum[4];
      status_nxt[`CX_FLAG_ZERO]  = cx_is_zero(sum[7:0]);
      acc_nxt = sum[7:0];
    end
    else if (instr_r[13:8] == `CX_OP6_AND_FILE)
    begin
      // Logic operations leave both carry flags as they were
      status_nxt[`CX_FLAG_ZERO] = cx_is_zero(acc_r & fval);
      if (dest)
      begin
        fres_nxt = acc_r & fval;
        fwr_nxt  = 1'b1;
      end
      else
        acc_nxt = acc_r & fval;
    end
    else if (instr_r[13:8] == `CX_OP6_AND_IMM)
    begin
      acc_nxt = acc_r & imm;
      status_nxt[`CX_FLAG_ZERO] = cx_is_zero(acc_r & imm);
    end
    else if (instr_r[13:8] == `CX_OP6_COPY_FILE)
    begin
      // Writing back to itself just tests the register for zero
      status_nxt[`CX_FLAG_ZERO] = cx_is_zero(fval);
      if (dest)
        fwr_nxt = 1'b1;
      else
        acc_nxt = fval;
    end
    else if (instr_r[13:7] == `CX_OP7_COPY_ACC)
    begin
      fres_nxt = acc_r;
      fwr_nxt  = 1'b1;
    end
    else if (instr_r[13:10] == `CX_OP4_BIT_CLEAR)
    begin
      // Bit operations rewrite one location; no flag moves
      fres_nxt = fval & ~bit_mask;
      fwr_nxt  = 1'b1;
    end
    else if (instr_r[13:10] == `CX_OP4_BIT_SET)
    begin
      fres_nxt = fval | bit_mask;
      fwr_nxt  = 1'b1;
    end
    else if (instr_r[13:10] == `CX_OP4_TEST_SKIP)
    begin
      // Only the skip flag moves; the tested register is not written
      skip_nxt = |(fval & bit_mask);
    end
    else if (instr_r[13:10] == `CX_OP4_LOAD_IMM)
    begin
      // Don't-care bits 9:8 are ignored; only the literal is used
      acc_nxt = imm;
    end
    else
    begin
      // No-op and unsupported codes leave all state alone
      acc_nxt = acc_r;
    end
  end

  // ----------------------------------------------------------------------
  // Commit on the execute strobe
  // ----------------------------------------------------------------------
  // The skip flag lives across words: the word after a taken test runs
  // as a no-op in its own four-period slot, so the test costs two cycles.
  // The executed count includes discarded words, as each takes a slot.
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_r        <= `CX_RST_ACC;
      status_r     <= `CX_RST_STATUS;
      skip_r       <= 1'b0;
      exec_count_r <= 16'h0000;
    end
    else if (exec)
    begin
      acc_r        <= acc_nxt;
      status_r     <= status_nxt;
      skip_r       <= skip_nxt;
      exec_count_r <= exec_count_r + 16'h0001;
    end
  end

  // File storage has no reset, like a plain RAM; software preloads it.
  // A bus write lands only at the edge that completes the transfer.
  always @(posedge sys_clk)
  begin
    if (exec && fwr_nxt)
      file_r[faddr] <= fres_nxt;
    else if (psel && penable && pwrite && pready
             && reg_sel == SEL_FILE)
      file_r[paddr[8:2]] <= pwdata[7:0];
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Instruction register only loads while idle; busy stalls via pready.
  // Reads return the last word written, so software can see what ran.
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      instr_r <= `CX_OP_NOP;
    else if (start)
      instr_r <= pwdata[13:0];
  end

  // Accesses answer after one wait state; busy cycle holds pready low
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= answer_now;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      // Unmapped addresses answer with an error after the same wait state, held off while busy
      if (answer_now)
      begin
        case (reg_sel)
          SEL_FILE:   prdata <= {24'h000000, file_r[paddr[8:2]]};
          SEL_ACC:    prdata <= {24'h000000, acc_r};
          SEL_STATUS: prdata <= {29'h0, status_r};
          SEL_COUNT:  prdata <= {16'h0000, exec_count_r};
          SEL_INSTR:  prdata <= {18'h0, instr_r};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Observation outputs
  // ----------------------------------------------------------------------
  // Registered copies so every output comes from a flop; they trail the
  // internal state by one clock, which software never notices
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_out   <= `CX_RST_ACC;
      flags_out <= `CX_RST_STATUS;
      skip_out  <= 1'b0;
    end
    else
    begin
      acc_out   <= acc_r;
      flags_out <= status_r;
      skip_out  <= skip_r;
    end
  end

endmodule // cx_execute

// >>> testbench/cx_asserts.sv
// APB answer checks for the execute datapath
`timescale 1ns/1ps
module cx_asserts
(
  input wire        sys_clk,
  input wire        arst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        skip_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  // Execution lasts four cycles, so twelve is ample
  AST_READY_BOUND: assert property (psel && penable |-> ##[0:12] pready)
    else $error("access never answered");
  AST_ACC_UPPER: assert property (pready && !pwrite && paddr == 12'h004
    |-> prdata[31:8] == 24'h0) else $error("accumulator too wide");
  AST_UNMAPPED: assert property (pready && paddr == 12'h010 |-> pslverr)
    else $error("unmapped not refused");
  AST_FILE_OK: assert property (pready && paddr[11:9] == 3'h1
    |-> !pslverr) else $error("file access refused");
  // An instruction write holds every answer off for the whole cycle
  AST_EXEC_STALL: assert property (pready && pwrite
    && paddr == 12'h000 |=> !pready [*4]) else $error("answer while busy");
  C_INSTR: cover property (pready && pwrite && paddr == 12'h000);
  C_ERR: cover property (pslverr);
  C_SKIP: cover property ($rose(skip_out));
endmodule // cx_asserts

bind cx_execute cx_asserts i_cx_asserts (.sys_clk, .arst_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .skip_out);

// >>> testbench/cx_ref_model.sv
// Reference model of the accumulator, flags and file registers
`timescale 1ns/1ps
`include "cx_map.vh"
module cx_ref_model;
  reg [7:0] acc_r = 8'h00;
  reg [2:0] flg_r = 3'h0;
  reg       skip_r = 1'b0;
  reg [7:0] file_r [0:127];
  // ----------------------------------------
  // One instruction; flags are {zero, half, carry}
  // ----------------------------------------
  task exec(input [13:0] w);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] k;
    reg       imm;
    begin
      imm = w[13:12] == 2'b11;
      k = imm ? w[7:0] : file_r[w[6:0]];
      if (skip_r)
        skip_r = 1'b0;
      else if (w[13:8] == `CX_OP6_ADD_IMM || w[13:8] == `CX_OP6_ADD_FILE)
      begin
        s = acc_r + k;
        h = acc_r[3:0] + k[3:0];
        flg_r = {s[7:0] == 8'h00, h[4], s[8]};
        put(imm, w, s[7:0]);
      end
      else if (w[13:8] == `CX_OP6_AND_IMM || w[13:8] == `CX_OP6_AND_FILE)
      begin
        flg_r[2] = (acc_r & k) == 8'h00;
        put(imm, w, acc_r & k);
      end
      else if (w[13:8] == `CX_OP6_COPY_FILE)
      begin
        flg_r[2] = k == 8'h00;
        put(1'b0, w, k);
      end
      else if (w[13:7] == `CX_OP7_COPY_ACC)
        file_r[w[6:0]] = acc_r;
      else if (w[13:10] == `CX_OP4_BIT_CLEAR)
        file_r[w[6:0]][w[9:7]] = 1'b0;
      else if (w[13:10] == `CX_OP4_BIT_SET)
        file_r[w[6:0]][w[9:7]] = 1'b1;
      else if (w[13:10] == `CX_OP4_TEST_SKIP)
        skip_r = k[w[9:7]];
      else if (w[13:10] == `CX_OP4_LOAD_IMM)
        acc_r = w[7:0];
    end
  endtask
  // Destination bit only counts for file-operand forms
  task put(input imm, input [13:0] w, input [7:0] v);
    begin
      if (!imm && w[7])
        file_r[w[6:0]] = v;
      else
        acc_r = v;
    end
  endtask
endmodule // cx_ref_model

// >>> testbench/testbench.sv
// Random and directed bench for the execute datapath
`timescale 1ns/1ps
`include "cx_map.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        skip_out;
  wire [7:0]  acc_out;
  wire [2:0]  flags_out;
  integer     errors = 0;
  integer     comparisons = 0;
  integer     i;
  integer     runs = 0;
  reg  [13:0] w_last = 14'h0000;
  reg  [31:0] seed = 32'hbf7a;
  reg  [31:0] q;
  reg         e;
  // Carry, half carry, zero, then a skip that swallows a load
  localparam [139:0] DIR = {14'h30ff, 14'h3e01, 14'h300f, 14'h3e01,
    14'h3900, 14'h3081, 14'h0085, 14'h1c05, 14'h3033, 14'h0000};
  always #4 sys_clk = ~sys_clk;
  cx_execute i_cx_execute (.sys_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .acc_out, .flags_out,
    .skip_out);
  cx_ref_model i_cx_ref_model ();
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [13:0] mk(input [3:0] k, input [9:0] r);
    case (k)
      0: mk = {`CX_OP6_ADD_IMM, r[7:0]};
      1: mk = {`CX_OP6_ADD_FILE, r[7:0]};
      2: mk = {`CX_OP6_AND_IMM, r[7:0]};
      3: mk = {`CX_OP6_AND_FILE, r[7:0]};
      4: mk = {`CX_OP4_BIT_CLEAR, r};
      5: mk = {`CX_OP4_BIT_SET, r};
      6: mk = {`CX_OP4_TEST_SKIP, r};
      7: mk = {`CX_OP6_COPY_FILE, r[7:0]};
      8: mk = {`CX_OP7_COPY_ACC, r[6:0]};
      9: mk = {`CX_OP4_LOAD_IMM, 2'b00, r[7:0]};
      default: mk = `CX_OP_NOP;
    endcase
  endfunction
  task stop_test;
    begin
      if (errors == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; held until pready, released after it
  task apb(input w, input [11:0] a, input [31:0] d,
    output [31:0] rd, output er);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 40);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40)
      begin
        errors = errors + 1;
        stop_test;
      end
    end
  endtask
  // Execute one word, then compare every visible result
  task run(input [13:0] w);
    begin
      runs = runs + 1;
      w_last = w;
      apb(1'b1, `CX_REG_INSTR, {18'h0, w}, q, e);
      i_cx_ref_model.exec(w);
      apb(1'b0, `CX_REG_ACC, 32'h0, q, e);
      chk(q, {24'h0, i_cx_ref_model.acc_r});
      apb(1'b0, `CX_REG_STATUS, 32'h0, q, e);
      chk(q[2:0], i_cx_ref_model.flg_r);
      apb(1'b0, {3'h1, w[6:0], 2'h0}, 32'h0, q, e);
      chk(q[7:0], i_cx_ref_model.file_r[w[6:0]]);
      chk({acc_out, flags_out, skip_out}, {i_cx_ref_model.acc_r,
        i_cx_ref_model.flg_r, i_cx_ref_model.skip_r});
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 128; i = i + 1)
    begin
      seed = lfsr(seed);
      i_cx_ref_model.file_r[i] = seed[7:0];
      apb(1'b1, {3'h1, i[6:0], 2'h0}, {24'h0, seed[7:0]}, q, e);
    end
    for (i = 0; i < 10; i = i + 1)
      run(DIR[139 - 14 * i -: 14]);
    // Accumulator is read-only from the bus
    apb(1'b1, `CX_REG_ACC, 32'h5a, q, e);
    chk(e, 1'b0);
    run(`CX_OP_NOP);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(e, 1'b1);
    for (i = 0; i < 200; i = i + 1)
    begin
      seed = lfsr(seed);
      run(mk(seed[19:16] % 4'd11, seed[9:0]));
    end
    // Every written word takes one slot, discarded ones included
    apb(1'b0, `CX_REG_EXEC_COUNT, 32'h0, q, e);
    chk(q, runs);
    apb(1'b0, `CX_REG_INSTR, 32'h0, q, e);
    chk(q, {18'h0, w_last});
    stop_test;
  end
endmodule // testbench
